// ==== rtl/irq_status_pkg.sv ====
// shared constants and carrier types of the interrupt status collector
package irq_status_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_INTERRUPT_STATUS = 8'h58;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE = 8'h5c;
    localparam logic [7:0] OFS_BYTE_TEST = 8'h64;
    localparam logic [7:0] OFS_LEVEL_CONFIG = 8'h68;

    // ------------------------------------------------------------------
    // values after reset and fixed read values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_INTERRUPT_STATUS = 32'h0000_0000;
    localparam logic [31:0] RST_INTERRUPT_ENABLE = 32'h0000_0000;
    localparam logic [31:0] RST_LEVEL_CONFIG = 32'h4800_0000;
    localparam logic [31:0] BYTE_TEST_VALUE = 32'h8765_4321;

    // ------------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------------
    localparam int BIT_SOFTWARE = 31;
    localparam int BIT_TX_HALTED = 25;
    localparam int BIT_RX_HALTED = 24;
    localparam int BIT_DROP_HALFWAY = 23;
    localparam int BIT_TX_COMPLETION = 21;
    localparam int BIT_RX_DMA = 20;
    localparam int BIT_TIMER_WRAP = 19;
    localparam int BIT_PHY_EVENT = 18;
    localparam int BIT_WAKE_EVENT = 17;
    localparam int BIT_TX_STATUS_OVERFLOW = 16;
    localparam int BIT_RX_WATCHDOG = 15;
    localparam int BIT_RX_ERROR = 14;
    localparam int BIT_TX_ERROR = 13;
    localparam int BIT_TX_DATA_OVERRUN = 10;
    localparam int BIT_TX_SPACE_AVAILABLE = 9;
    localparam int BIT_TX_STATUS_FULL = 8;
    localparam int BIT_TX_STATUS_LEVEL = 7;
    localparam int BIT_RX_FRAME_DROPPED = 6;
    localparam int BIT_RX_STATUS_FULL = 4;
    localparam int BIT_RX_STATUS_LEVEL = 3;
    localparam int BIT_PIN_EVENT_LO = 0;

    // write-one-to-clear bits, and every implemented bit (phy bit is read-only)
    localparam logic [31:0] STATUS_W1C_MASK = 32'h83bb_e7df;
    localparam logic [31:0] STATUS_IMPL_MASK = 32'h83bf_e7df;
    localparam logic [31:0] LEVEL_CONFIG_MASK = 32'hffff_00ff;

    // level config field positions (tx space in 64 byte blocks, status in words)
    localparam int LVL_TX_SPACE_LO = 24;
    localparam int LVL_TX_STATUS_LO = 16;
    localparam int LVL_RX_STATUS_LO = 0;
    localparam int LVL_FIELD_W = 8;

    // dropped frame counter halfway crossing, timer wrap values
    localparam logic [31:0] DROP_COUNT_BELOW_HALF = 32'h07ff_ffff;
    localparam logic [31:0] DROP_COUNT_AT_HALF = 32'h0800_0000;
    localparam logic [15:0] TIMER_ZERO = 16'h0000;
    localparam logic [15:0] TIMER_WRAPPED = 16'hffff;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic tx_stop_request;
        logic tx_idle;
        logic rx_halted;
        logic [31:0] drop_count;
        logic tx_completion;
        logic rx_dma_done;
        logic [15:0] timer_count;
        logic phy_event;
        logic wake_detect;
        logic tx_status_overflow;
        logic rx_too_long;
        logic rx_error;
        logic tx_error;
        logic tx_write_when_full;
        logic [7:0] tx_free_blocks;
        logic tx_status_full;
        logic [7:0] tx_status_used;
        logic rx_frame_dropped;
        logic rx_status_full;
        logic [7:0] rx_status_used;
        logic [2:0] pin_events;
        logic enter_low_power;
    } event_in_t;

endpackage

// ==== rtl/interrupt_status_collector.sv ====
// interrupt status register with its enable mask, level thresholds and wake logic
module interrupt_status_collector
    import irq_status_pkg::*;
#(
    parameter int LEVEL_W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register bus
    input wire apb_req_t apb_req,
    output apb_rsp_t apb_rsp,
    // event sources
    input wire event_in_t ev,
    // interrupt and power outputs
    output logic irq_master,
    output logic wake_irq,
    output logic low_power
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (LEVEL_W < 1 || LEVEL_W > LVL_FIELD_W) begin : g_bad_level_w
        $error("LEVEL_W must lie between 1 and 8");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] enable;
        logic [31:0] level_cfg;
        logic [31:0] drop_prev;
        logic [15:0] timer_prev;
        logic rx_halted_prev;
        logic tx_halt_prev;
        logic low_power;
        logic [31:0] rdata;
        logic slverr;
    } state_t;

    localparam state_t STATE_RESET = '{
        status: RST_INTERRUPT_STATUS,
        enable: RST_INTERRUPT_ENABLE,
        level_cfg: RST_LEVEL_CONFIG,
        drop_prev: 32'h0000_0000,
        timer_prev: TIMER_WRAPPED,
        rx_halted_prev: 1'b0,
        tx_halt_prev: 1'b0,
        low_power: 1'b0,
        rdata: 32'h0000_0000,
        slverr: 1'b0
    };

    state_t st_ff;
    state_t nxt_st;

    function automatic logic addr_mapped(input logic [7:0] addr);
        return addr == OFS_INTERRUPT_STATUS || addr == OFS_INTERRUPT_ENABLE ||
               addr == OFS_BYTE_TEST || addr == OFS_LEVEL_CONFIG;
    endfunction

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic setup_phase;
    logic access_wr;
    logic wr_status;
    logic wr_enable;
    logic wr_byte_test;
    logic wr_level;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic tx_halt_now;
    logic [LEVEL_W-1:0] thr_tx_space;
    logic [LEVEL_W-1:0] thr_tx_status;
    logic [LEVEL_W-1:0] thr_rx_status;

    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign access_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign wr_status = access_wr && apb_req.paddr == OFS_INTERRUPT_STATUS;
    assign wr_enable = access_wr && apb_req.paddr == OFS_INTERRUPT_ENABLE;
    assign wr_byte_test = access_wr && apb_req.paddr == OFS_BYTE_TEST;
    assign wr_level = access_wr && apb_req.paddr == OFS_LEVEL_CONFIG;
    assign tx_halt_now = ev.tx_stop_request && ev.tx_idle;

    // thresholds compared in the units of their counts: blocks for tx data, words for status
    assign thr_tx_space = st_ff.level_cfg[LVL_TX_SPACE_LO +: LEVEL_W];
    assign thr_tx_status = st_ff.level_cfg[LVL_TX_STATUS_LO +: LEVEL_W];
    assign thr_rx_status = st_ff.level_cfg[LVL_RX_STATUS_LO +: LEVEL_W];

    // ------------------------------------------------------------------
    // event collection: not gated by the enable mask, except the software flag, set only while its enable bit is still off
    // ------------------------------------------------------------------
    always_comb begin
        set_vec = 32'h0000_0000;
        // a write that turns the software enable on raises the software flag
        set_vec[BIT_SOFTWARE] = wr_enable && apb_req.pwdata[BIT_SOFTWARE] &&
                                !st_ff.enable[BIT_SOFTWARE];
        set_vec[BIT_TX_HALTED] = tx_halt_now && !st_ff.tx_halt_prev;
        set_vec[BIT_RX_HALTED] = ev.rx_halted && !st_ff.rx_halted_prev;
        set_vec[BIT_DROP_HALFWAY] = st_ff.drop_prev == DROP_COUNT_BELOW_HALF &&
                                    ev.drop_count == DROP_COUNT_AT_HALF;
        set_vec[BIT_TX_COMPLETION] = ev.tx_completion;
        set_vec[BIT_RX_DMA] = ev.rx_dma_done;
        set_vec[BIT_TIMER_WRAP] = st_ff.timer_prev == TIMER_ZERO &&
                                  ev.timer_count == TIMER_WRAPPED;
        set_vec[BIT_WAKE_EVENT] = ev.wake_detect;
        set_vec[BIT_TX_STATUS_OVERFLOW] = ev.tx_status_overflow;
        set_vec[BIT_RX_WATCHDOG] = ev.rx_too_long;
        set_vec[BIT_RX_ERROR] = ev.rx_error;
        set_vec[BIT_TX_ERROR] = ev.tx_error;
        set_vec[BIT_TX_DATA_OVERRUN] = ev.tx_write_when_full;
        // level flags re-arm every cycle the condition holds, so a clear while
        // the fifo still sits past its level reads back as set
        set_vec[BIT_TX_SPACE_AVAILABLE] = ev.tx_free_blocks[LEVEL_W-1:0] > thr_tx_space;
        set_vec[BIT_TX_STATUS_FULL] = ev.tx_status_full;
        set_vec[BIT_TX_STATUS_LEVEL] = ev.tx_status_used[LEVEL_W-1:0] > thr_tx_status;
        set_vec[BIT_RX_FRAME_DROPPED] = ev.rx_frame_dropped;
        set_vec[BIT_RX_STATUS_FULL] = ev.rx_status_full;
        set_vec[BIT_RX_STATUS_LEVEL] = ev.rx_status_used[LEVEL_W-1:0] > thr_rx_status;
        set_vec[BIT_PIN_EVENT_LO +: 3] = ev.pin_events;
    end

    // only ones written to write-to-clear positions clear; phy and reserved ignore it
    assign clr_vec = wr_status ? (apb_req.pwdata & STATUS_W1C_MASK) : 32'h0000_0000;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // set wins over a clear landing in the same cycle
        nxt_st.status = ((st_ff.status & ~clr_vec) | set_vec) & STATUS_W1C_MASK;
        nxt_st.status[BIT_PHY_EVENT] = ev.phy_event;
        nxt_st.status = nxt_st.status & STATUS_IMPL_MASK;
        nxt_st.drop_prev = ev.drop_count;
        nxt_st.timer_prev = ev.timer_count;
        nxt_st.rx_halted_prev = ev.rx_halted;
        nxt_st.tx_halt_prev = tx_halt_now;
        if (wr_enable) begin
            nxt_st.enable = apb_req.pwdata & STATUS_IMPL_MASK;
        end
        if (wr_level) begin
            nxt_st.level_cfg = apb_req.pwdata & LEVEL_CONFIG_MASK;
        end
        // a wake event alone leaves low power untouched; any byte test write ends it
        if (wr_byte_test) begin
            nxt_st.low_power = 1'b0;
        end else if (ev.enter_low_power) begin
            nxt_st.low_power = 1'b1;
        end
        // read data is fetched in the setup phase so it comes from flops
        if (setup_phase) begin
            nxt_st.slverr = !addr_mapped(apb_req.paddr);
            if (apb_req.pwrite) begin
                nxt_st.rdata = 32'h0000_0000;
            end else if (apb_req.paddr == OFS_INTERRUPT_STATUS) begin
                nxt_st.rdata = st_ff.status;
            end else if (apb_req.paddr == OFS_INTERRUPT_ENABLE) begin
                nxt_st.rdata = st_ff.enable;
            end else if (apb_req.paddr == OFS_BYTE_TEST) begin
                nxt_st.rdata = BYTE_TEST_VALUE;
            end else if (apb_req.paddr == OFS_LEVEL_CONFIG) begin
                nxt_st.rdata = st_ff.level_cfg;
            end else begin
                nxt_st.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= STATE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.prdata = st_ff.rdata;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && st_ff.slverr;
    assign irq_master = |(st_ff.status & st_ff.enable);
    // separate path so the external hold-off timer never delays the wake interrupt
    assign wake_irq = st_ff.status[BIT_WAKE_EVENT] && st_ff.enable[BIT_WAKE_EVENT];
    assign low_power = st_ff.low_power;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    chk_one_clears: assert property (
        wr_status && set_vec == 32'h0000_0000 |=>
            (st_ff.status & $past(apb_req.pwdata) & STATUS_W1C_MASK) == 32'h0000_0000)
        else $error("written one did not clear its status bit");

    chk_zero_keeps: assert property (
        1'b1 |=> (($past(st_ff.status) & ~$past(clr_vec) & STATUS_W1C_MASK) & ~st_ff.status) == 32'h0000_0000)
        else $error("status bit dropped without a clearing one");

    chk_set_wins: assert property (
        set_vec != 32'h0000_0000 |=> (st_ff.status & $past(set_vec)) == $past(set_vec))
        else $error("event lost against a clearing write");

    chk_soft_irq: assert property (
        wr_enable && apb_req.pwdata[BIT_SOFTWARE] && !st_ff.enable[BIT_SOFTWARE] |=>
            st_ff.status[BIT_SOFTWARE] && st_ff.enable[BIT_SOFTWARE])
        else $error("software flag not raised by enable");

    chk_phy_follows: assert property (
        1'b1 |=> st_ff.status[BIT_PHY_EVENT] == $past(ev.phy_event))
        else $error("phy status does not follow phy event");

    chk_drop_halfway: assert property (
        ev.drop_count == DROP_COUNT_BELOW_HALF ##1 ev.drop_count == DROP_COUNT_AT_HALF |=>
            st_ff.status[BIT_DROP_HALFWAY])
        else $error("halfway crossing not flagged");

    chk_timer_wrap: assert property (
        ev.timer_count == TIMER_ZERO ##1 ev.timer_count == TIMER_WRAPPED |=>
            st_ff.status[BIT_TIMER_WRAP])
        else $error("timer wrap not flagged");

    chk_tx_halted: assert property (
        $rose(ev.tx_stop_request && ev.tx_idle) |=> st_ff.status[BIT_TX_HALTED])
        else $error("tx halt not flagged");

    chk_space_level: assert property (
        ev.tx_free_blocks[LEVEL_W-1:0] > st_ff.level_cfg[LVL_TX_SPACE_LO +: LEVEL_W] |=>
            st_ff.status[BIT_TX_SPACE_AVAILABLE])
        else $error("tx space level not flagged");

    chk_reserved_zero: assert property (
        (st_ff.status & ~STATUS_IMPL_MASK) == 32'h0000_0000 &&
            (st_ff.enable & ~STATUS_IMPL_MASK) == 32'h0000_0000)
        else $error("reserved bit became set");

    chk_stay_asleep: assert property (
        st_ff.low_power && !wr_byte_test |=> st_ff.low_power)
        else $error("left low power without byte test write");

    chk_wake_by_test: assert property (
        wr_byte_test |=> !st_ff.low_power)
        else $error("byte test write did not wake");

    chk_master_or: assert property (
        irq_master == |(st_ff.status & st_ff.enable))
        else $error("master line differs from enabled status");

    chk_wake_irq: assert property (
        ev.wake_detect && st_ff.enable[BIT_WAKE_EVENT] && !wr_enable |=> wake_irq)
        else $error("wake interrupt not delivered next cycle");

    chk_read_data: assert property (
        setup_phase && !apb_req.pwrite && apb_req.paddr == OFS_BYTE_TEST |=>
            apb_rsp.prdata == BYTE_TEST_VALUE)
        else $error("byte test read value wrong");

    chk_rx_halted: assert property (
        $rose(ev.rx_halted) |=> st_ff.status[BIT_RX_HALTED])
        else $error("rx halt not flagged");

    chk_tx_completion: assert property (
        ev.tx_completion |=> st_ff.status[BIT_TX_COMPLETION])
        else $error("tx completion not flagged");

    chk_rx_dma: assert property (
        ev.rx_dma_done |=> st_ff.status[BIT_RX_DMA])
        else $error("rx dma completion not flagged");

    chk_wake_event: assert property (
        ev.wake_detect |=> st_ff.status[BIT_WAKE_EVENT])
        else $error("wake event not flagged");

    chk_tx_overflow: assert property (
        ev.tx_status_overflow |=> st_ff.status[BIT_TX_STATUS_OVERFLOW])
        else $error("tx status overflow not flagged");

    chk_rx_watchdog: assert property (
        ev.rx_too_long |=> st_ff.status[BIT_RX_WATCHDOG])
        else $error("oversize packet not flagged");

    chk_rx_error: assert property (
        ev.rx_error |=> st_ff.status[BIT_RX_ERROR])
        else $error("rx error not flagged");

    chk_tx_error: assert property (
        ev.tx_error |=> st_ff.status[BIT_TX_ERROR])
        else $error("tx error not flagged");

    chk_tx_overrun: assert property (
        ev.tx_write_when_full |=> st_ff.status[BIT_TX_DATA_OVERRUN])
        else $error("tx data overrun not flagged");

    chk_tx_status_full: assert property (
        ev.tx_status_full |=> st_ff.status[BIT_TX_STATUS_FULL])
        else $error("tx status full not flagged");

    chk_frame_dropped: assert property (
        ev.rx_frame_dropped |=> st_ff.status[BIT_RX_FRAME_DROPPED])
        else $error("dropped frame not flagged");

    chk_rx_status_full: assert property (
        ev.rx_status_full |=> st_ff.status[BIT_RX_STATUS_FULL])
        else $error("rx status full not flagged");

    chk_pin_events: assert property (
        ev.pin_events != 3'h0 |=> (st_ff.status[2:0] & $past(ev.pin_events)) == $past(ev.pin_events))
        else $error("pin event not latched");

    cov_timer_wrap: cover property ($rose(st_ff.status[BIT_TIMER_WRAP]));
    cov_clear_race: cover property (wr_status && (clr_vec & set_vec) != 32'h0000_0000);
    cov_wake_cycle: cover property (st_ff.low_power ##1 ev.wake_detect ##[1:20] wr_byte_test);
    cov_irq_raised: cover property ($rose(irq_master) ##[1:50] $fell(irq_master));
    cov_bad_addr: cover property (apb_rsp.pslverr);

endmodule

// ==== tb/tb_interrupt_status_collector.sv ====
// self-checking testbench of the interrupt status collector
module tb_interrupt_status_collector
    import irq_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic mclk;
    logic resetn;
    apb_req_t apb_req;
    apb_rsp_t apb_rsp;
    event_in_t ev;
    event_in_t ev_idle;
    logic irq_master;
    logic wake_irq;
    logic low_power;
    int n_fail;
    int total_checks;
    int k;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [31:0] model;
    logic [31:0] en;
    logic err;

    // one entry per event case of fire; zero where the case must not set anything
    localparam logic [31:0] EXP [22] = '{
        32'h02000000, 32'h01000000, 32'h00800000, 32'h00200000, 32'h00100000, 32'h00080000,
        32'h00020000, 32'h00010000, 32'h00008000, 32'h00004000, 32'h00002000, 32'h00000400,
        32'h00000200, 32'h00000100, 32'h00000080, 32'h00000040, 32'h00000010, 32'h00000008,
        32'h00000007, 32'h00000000, 32'h00000000, 32'h00000000};

    interrupt_status_collector #(.LEVEL_W(8)) u_interrupt_status_collector (
        .mclk(mclk),
        .resetn(resetn),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .ev(ev),
        .irq_master(irq_master),
        .wake_irq(wake_irq),
        .low_power(low_power)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] irq_of(input logic [31:0] st, input logic [31:0] mask);
        return {31'h0, |(st & mask)};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // request held from just after an edge until the edge that samples pready
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge mclk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= addr;
        apb_req.pwdata <= data;
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        // no wait-state count assumed: only the watchdog ends a stalled access
        do @(posedge mclk);
        while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(rd, exp);
    endtask

    // two-cycle stimulus so counter crossings see both values back to back
    task automatic fire(input int n);
        event_in_t e1;
        event_in_t e2;
        e1 = ev_idle;
        e1.tx_idle = (n == 0);
        case (n)
            0, 20: e1.tx_stop_request = 1'b1;
            1: e1.rx_halted = 1'b1;
            2: e1.drop_count = 32'h07ffffff;
            3: e1.tx_completion = 1'b1;
            4: e1.rx_dma_done = 1'b1;
            5: e1.timer_count = 16'h0000;
            6: e1.wake_detect = 1'b1;
            7: e1.tx_status_overflow = 1'b1;
            8: e1.rx_too_long = 1'b1;
            9: e1.rx_error = 1'b1;
            10: e1.tx_error = 1'b1;
            11: e1.tx_write_when_full = 1'b1;
            12: e1.tx_free_blocks = 8'h49;
            13: e1.tx_status_full = 1'b1;
            14: e1.tx_status_used = 8'h06;
            15: e1.rx_frame_dropped = 1'b1;
            16: e1.rx_status_full = 1'b1;
            17: e1.rx_status_used = 8'h01;
            18: e1.pin_events = 3'h7;
            19: e1.tx_free_blocks = 8'h48;
            21: e1.tx_status_used = 8'h05;
            default: e1 = ev_idle;
        endcase
        e2 = ev_idle;
        if (n == 2) e2.drop_count = 32'h08000000;
        if (n == 5) e2.timer_count = 16'hffff;
        @(posedge mclk);
        ev <= e1;
        @(posedge mclk);
        ev <= e2;
        @(posedge mclk);
        ev <= ev_idle;
    endtask

    // ------------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        #100000;
        n_fail++;
        close_out();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        ev_idle = '0;
        ev_idle.timer_count = 16'h1234;
        ev = ev_idle;
        apb_req = '0;
        resetn = 1'b0;
        n_fail = 0;
        total_checks = 0;
        seed = 32'h738b;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        rdchk(OFS_INTERRUPT_STATUS, 32'h0);
        rdchk(OFS_INTERRUPT_ENABLE, 32'h0);
        rdchk(OFS_LEVEL_CONFIG, 32'h48000000);
        rdchk(OFS_BYTE_TEST, 32'h87654321);
        rdchk(8'h60, 32'h0);
        check(err, 32'h1);
        // tx status threshold 5: a fill of exactly 5 must not raise the level flag
        apb(1'b1, OFS_LEVEL_CONFIG, 32'h4805ff00);
        rdchk(OFS_LEVEL_CONFIG, 32'h48050000);
        for (k = 0; k < 22; k++) begin
            fire(k);
            rdchk(OFS_INTERRUPT_STATUS, EXP[k]);
            seed = lfsr(seed);
            apb(1'b1, OFS_INTERRUPT_STATUS, seed & ~EXP[k]);
            rdchk(OFS_INTERRUPT_STATUS, EXP[k]);
            apb(1'b1, OFS_INTERRUPT_STATUS, EXP[k]);
            rdchk(OFS_INTERRUPT_STATUS, 32'h0);
        end
        @(posedge mclk);
        ev.phy_event <= 1'b1;
        rdchk(OFS_INTERRUPT_STATUS, 32'h00040000);
        apb(1'b1, OFS_INTERRUPT_STATUS, 32'hffffffff);
        rdchk(OFS_INTERRUPT_STATUS, 32'h00040000);
        @(posedge mclk);
        ev.phy_event <= 1'b0;
        rdchk(OFS_INTERRUPT_STATUS, 32'h0);
        apb(1'b1, OFS_INTERRUPT_ENABLE, 32'h80020000);
        rdchk(OFS_INTERRUPT_STATUS, 32'h80000000);
        check(irq_master, 32'h1);
        check(wake_irq, 32'h0);
        fire(6);
        rdchk(OFS_INTERRUPT_STATUS, 32'h80020000);
        check(wake_irq, 32'h1);
        apb(1'b1, OFS_INTERRUPT_STATUS, 32'h80020000);
        rdchk(OFS_INTERRUPT_STATUS, 32'h0);
        check(irq_master, 32'h0);
        check(wake_irq, 32'h0);
        model = 32'h0;
        for (k = 0; k < 24; k++) begin
            seed = lfsr(seed);
            en = {29'h0, seed[9:7]};
            apb(1'b1, OFS_INTERRUPT_ENABLE, en);
            @(posedge mclk);
            ev.pin_events <= seed[2:0];
            @(posedge mclk);
            ev.pin_events <= 3'h0;
            model = model | {29'h0, seed[2:0]};
            apb(1'b1, OFS_INTERRUPT_STATUS, {29'h0, seed[6:4]});
            model = model & ~{29'h0, seed[6:4]};
            rdchk(OFS_INTERRUPT_STATUS, model);
            check(irq_master, irq_of(model, en));
        end
        // event held across the clearing edge: the set has to win
        @(posedge mclk);
        ev.rx_error <= 1'b1;
        apb(1'b1, OFS_INTERRUPT_STATUS, 32'h00004000);
        ev.rx_error <= 1'b0;
        rdchk(OFS_INTERRUPT_STATUS, model | 32'h00004000);
        apb(1'b1, OFS_INTERRUPT_STATUS, 32'h00004007);
        rdchk(OFS_INTERRUPT_STATUS, 32'h0);
        @(posedge mclk);
        ev.enter_low_power <= 1'b1;
        @(posedge mclk);
        ev.enter_low_power <= 1'b0;
        fire(6);
        check(low_power, 32'h1);
        apb(1'b1, OFS_INTERRUPT_STATUS, 32'hffffffff);
        check(low_power, 32'h1);
        apb(1'b1, OFS_BYTE_TEST, seed);
        @(posedge mclk);
        check(low_power, 32'h0);
        rdchk(OFS_BYTE_TEST, 32'h87654321);
        close_out();
    end
endmodule
